// ---- bench/capacitive_sense_scan_control_test.sv ----
/*
  Self-checking bench of the capacitive sense scan control.
  Assumes css_top on one 10 MHz clock, an AHB-Lite master here and a sensor model on the front end.
*/
`timescale 1ns/100ps
`include "css_defs.svh"
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("BAD %s expected %0h seen %0h", nm, ex, got); end end
module capacitive_sense_scan_control_test;
  logic              hclk;
  logic              hresetn;
  logic              hwrite;
  logic              hreadyout;
  logic              hresp;
  logic              wake;
  logic              complete_irq;
  logic              conv_active;
  logic [1:0]        htrans;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic [7:0]        pin_ground;
  logic [7:0]        analog_cfg;
  logic [7:0]        port_latch;
  logic [15:0]       fe_result;
  css_pkg::css_evt_t evt;
  int                err_total;
  int                n_tests;
  int                cyc;
  int                wakes;
  int                n;
  int                n8;
  int                n6;
  logic [2:0]        src_tab [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
  int                tmr_tab [4] = '{0, 2, 1, 3};
  logic [31:0]       chan_tab [4] = '{32'h3, 32'h4, 32'h5, 32'h3};

  css_top #(.NCH(8)) css_top_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .evt(evt), .analog_cfg(analog_cfg), .port_latch(port_latch),
    .fe_result(fe_result), .pin_ground(pin_ground), .complete_irq(complete_irq), .wake(wake),
    .conv_active(conv_active));
  css_sensor_model css_sensor_model_inst (.hclk(hclk), .conv_active(conv_active), .fe_result(fe_result));

  initial hclk = 1'b0;
  always #50 hclk = ~hclk;

  // Cycle count cuts a hang short; wake pulses are counted for the suspend test.
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1)
      wakes <= wakes + 1;
    if (cyc == 90000) begin
      err_total++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Bus and wait tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hwrite <= wr;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wait_conv(input logic v, output int cnt);
    cnt = 0;
    while (conv_active !== v && cnt < 40000) begin
      @(posedge hclk);
      cnt++;
    end
    `CHECK("conv_active", v, conv_active)
  endtask

  task automatic quiet(input int cnt);
    int hits;
    hits = 0;
    repeat (cnt) begin
      @(posedge hclk);
      if (conv_active !== 1'b0)
        hits++;
    end
    `CHECK("idle cycles", 0, hits)
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    evt = '0;
    cyc = 0;
    wakes = 0;
    err_total = 0;
    n_tests = 0;
    analog_cfg = 8'hEF;
    port_latch = 8'h81;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, `CSS_OFF_MD1, 32'h0);
    `CHECK("gain", 3'h7, rd[2:0])
    bus(1'b0, `CSS_OFF_MD2, 32'h0);
    `CHECK("resolution", 2'h1, rd[1:0])
    bus(1'b0, 8'h40, 32'h0);
    `CHECK("unmapped", 32'h0, rd)
    `CHECK("hresp", 1'b0, hresp)
    bus(1'b1, `CSS_OFF_CTRL, 32'h10);
    quiet(20);
    $display("test reset and disable done");
    bus(1'b1, `CSS_OFF_IEN, 32'h1);
    bus(1'b1, `CSS_OFF_MUX, 32'h2);
    bus(1'b1, `CSS_OFF_THR, 32'h1000);
    bus(1'b1, `CSS_OFF_CTRL, 32'hA1);
    bus(1'b1, `CSS_OFF_CTRL, 32'hB1);
    @(posedge hclk);
    bus(1'b0, `CSS_OFF_CTRL, 32'h0);
    `CHECK("busy", 1'b1, rd[4])
    wait_conv(1'b1, n);
    repeat (5) @(posedge hclk);
    `CHECK("pin_ground", 8'h6A, pin_ground)
    wait_conv(1'b0, n8);
    `CHECK("length 8x", 1'b1, n8 > 300 && n8 < 330)
    repeat (4) @(posedge hclk);
    bus(1'b0, `CSS_OFF_CTRL, 32'h0);
    `CHECK("complete and busy", 2'h2, rd[5:4])
    `CHECK("threshold flag", 1'b1, rd[0])
    `CHECK("complete_irq", 1'b1, complete_irq)
    bus(1'b1, `CSS_OFF_CTRL, 32'h80);
    repeat (2) @(posedge hclk);
    `CHECK("complete_irq cleared", 1'b0, complete_irq)
    bus(1'b1, `CSS_OFF_MD1, 32'h5);
    bus(1'b1, `CSS_OFF_THR, 32'hFFFF);
    bus(1'b1, `CSS_OFF_CTRL, 32'h90);
    wait_conv(1'b1, n);
    wait_conv(1'b0, n6);
    `CHECK("length 6x", 1'b1, n6 > n8)
    repeat (4) @(posedge hclk);
    bus(1'b0, `CSS_OFF_CTRL, 32'h0);
    `CHECK("threshold flag", 1'b0, rd[0])
    bus(1'b1, `CSS_OFF_MD1, 32'h7);
    $display("test software start done");
    foreach (src_tab[i]) begin
      bus(1'b1, `CSS_OFF_CFG, {25'h0, src_tab[i], 4'h0});
      evt.t_ovf <= 4'h1 << ((tmr_tab[i] + 1) % 4);
      @(posedge hclk);
      evt.t_ovf <= 4'h0;
      quiet(20);
      evt.t_ovf <= 4'h1 << tmr_tab[i];
      @(posedge hclk);
      evt.t_ovf <= 4'h0;
      wait_conv(1'b1, n);
      wait_conv(1'b0, n);
    end
    $display("test timer sources done");
    bus(1'b1, `CSS_OFF_CFG, 32'h50);
    quiet(50);
    bus(1'b1, `CSS_OFF_CTRL, 32'h90);
    wait_conv(1'b1, n);
    wait_conv(1'b0, n);
    wait_conv(1'b1, n);
    `CHECK("restart gap", 1'b1, n < 10)
    bus(1'b1, `CSS_OFF_CTRL, 32'h0);
    wait_conv(1'b0, n);
    quiet(200);
    $display("test continuous done");
    bus(1'b1, `CSS_OFF_CTRL, 32'h80);
    bus(1'b1, `CSS_OFF_CFG, 32'h70);
    bus(1'b1, `CSS_OFF_SS, 32'h3);
    bus(1'b0, `CSS_OFF_MUX, 32'h0);
    `CHECK("mux copy", 32'h3, rd)
    bus(1'b1, `CSS_OFF_SE, 32'h5);
    bus(1'b1, `CSS_OFF_CTRL, 32'h90);
    foreach (chan_tab[i]) begin
      wait_conv(1'b1, n);
      bus(1'b0, `CSS_OFF_MUX, 32'h0);
      `CHECK("scan channel", chan_tab[i], rd)
      wait_conv(1'b0, n);
    end
    evt.suspend <= 1'b1;
    bus(1'b1, `CSS_OFF_THR, 32'h0);
    wait_conv(1'b1, n);
    wait_conv(1'b0, n);
    repeat (4) @(posedge hclk);
    bus(1'b0, `CSS_OFF_CTRL, 32'h0);
    `CHECK("threshold flag", 1'b1, rd[0])
    quiet(300);
    bus(1'b0, `CSS_OFF_MUX, 32'h0);
    `CHECK("held channel", 32'h4, rd)
    `CHECK("wake", 1'b1, wakes > 0)
    $display("test auto-scan done");
    complete_run();
  end
endmodule

// ---- bench/css_sensor_model.sv ----
/*
  Sense electrode model: hands the front end a count while a conversion runs.
  Assumes conv_active marks a conversion; outside it and a short settle the count churns.
*/
`timescale 1ns/100ps
module css_sensor_model #(
  parameter logic [15:0] COUNT = 16'h1234
) (
  // Clock and conversion state
  input  wire logic        hclk,
  input  wire logic        conv_active,
  // Front end count
  output logic [15:0]      fe_result
);
  logic [1:0] hold;

  initial begin
    hold      = 2'h0;
    fe_result = 16'h0000;
  end

  // The count stands through a conversion and three settle cycles; otherwise it is not kept.
  always @(posedge hclk) begin
    hold <= conv_active ? 2'h3 : ((hold != 2'h0) ? hold - 2'h1 : 2'h0);
    fe_result <= (conv_active || hold != 2'h0) ? COUNT : ~fe_result;
  end
endmodule

// ---- hw/css_defs.svh ----
/*
  Constants of the capacitive sense scan control: register offsets, field positions, reset values, timing counts.
  Assumes a 32-bit AHB-Lite register window and a 10 MHz system clock.
*/
`ifndef CSS_DEFS_SVH
`define CSS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define CSS_OFF_CTRL      8'h00
`define CSS_OFF_CFG       8'h04
`define CSS_OFF_MD1       8'h08
`define CSS_OFF_MD2       8'h0C
`define CSS_OFF_MUX       8'h10
`define CSS_OFF_SS        8'h14
`define CSS_OFF_SE        8'h18
`define CSS_OFF_THR       8'h1C
`define CSS_OFF_RES       8'h20
`define CSS_OFF_IEN       8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CSS_CTRL_EN       7
`define CSS_CTRL_INT      5
`define CSS_CTRL_BUSY     4
`define CSS_CTRL_CMPF     0
`define CSS_CFG_SRC_HI    6
`define CSS_CFG_SRC_LO    4
`define CSS_IEN_CPT       0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CSS_GAIN_RESET    3'h7
`define CSS_RES_RESET     2'h1
`define CSS_THR_RESET     16'h0000

// ----------------------------------------------------------------
// Timing: conversion time at 8x and 1x gain, 13-bit
// ----------------------------------------------------------------
`define CSS_CLK_MHZ       10
`define CSS_T8X_US        31
`define CSS_T1X_US        178
`define CSS_CYC_8X        (`CSS_T8X_US * `CSS_CLK_MHZ)
`define CSS_CYC_1X        (`CSS_T1X_US * `CSS_CLK_MHZ)

`endif

// ---- hw/css_ground.sv ----
/*
  Grounding mask for idle sense pins during a conversion.
  Assumes analog and latch maps are steady inputs.
*/
`timescale 1ns/100ps
module css_ground #(
  parameter int NCH = 38
) (
  // Pin state
  input  wire logic [NCH-1:0] analog_cfg,
  input  wire logic [NCH-1:0] port_latch,
  input  wire logic [5:0]     channel,
  input  wire logic           active,
  // Mask
  output logic [NCH-1:0]      ground
);
  genvar i;
  generate
    for (i = 0; i < NCH; i++) begin : g_pin
      assign ground[i] = active && analog_cfg[i] && !port_latch[i] && (channel != 6'(i));
    end
  endgenerate
endmodule

// ---- hw/css_pkg.sv ----
/*
  Types of the capacitive sense scan control.
  Assumes css_defs.svh is included by the users that need constants.
*/
package css_pkg;
  typedef enum logic [2:0] {
    CSS_SRC_BUSY, CSS_SRC_T0, CSS_SRC_T2, CSS_SRC_T1, CSS_SRC_T3, CSS_SRC_CONT, CSS_SRC_RSV, CSS_SRC_SCAN
  } css_src_t;

  typedef struct packed {
    logic [3:0] t_ovf;
    logic       debug_halt;
    logic       suspend;
  } css_evt_t;
endpackage

// ---- hw/css_timer.sv ----
/*
  Conversion timer: counts out one conversion whose length depends on gain and resolution.
  Assumes start pulses only while idle.
*/
`timescale 1ns/100ps
`include "css_defs.svh"
module css_timer (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // Control
  input  wire logic        start,
  input  wire logic [2:0]  gain,
  input  wire logic [1:0]  res,
  // Status
  output logic             done
);
  logic [15:0] cnt;
  logic [15:0] base;
  logic [15:0] len;
  logic        run;
  logic [3:0]  gplus;

  // Conversion time scales as the inverse of the gain.
  assign gplus = {1'b0, gain} + 4'h1;
  assign base  = 16'((`CSS_CYC_8X * 8) / gplus);
  // Resolution adjusts length by one sixteenth per bit from 12 to 14 bits; 16 bits adds one quarter.
  assign len   = (res == 2'h0) ? 16'(base - (base >> 4)) :
                 (res == 2'h1) ? base :
                 (res == 2'h2) ? 16'(base + (base >> 4)) : 16'(base + (base >> 2));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt  <= 16'h0000;
      run  <= 1'b0;
      done <= 1'b0;
    end else if (ce) begin
      done <= 1'b0;
      if (start) begin
        cnt <= len;
        run <= 1'b1;
      end else if (run) begin
        if (cnt <= 16'h0001) begin
          run  <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt <= cnt - 16'h0001;
        end
      end
    end
  end
endmodule

// ---- hw/css_top.sv ----
/*
  Capacitive sense scan control: AHB-Lite registers, trigger selection, auto-scan sequencing, comparator flag.
  Assumes one system clock, synchronous pin inputs and a measurement front end giving a 16-bit result.
*/
// Added by the designer: the placing of the registers and the AHB-Lite slave port.
// Contract
// R1 - Works only while sense_enable is one
// R2 - Software sets measured pins as analog inputs
// R3 - Ground other reachable analog zero-latch pins
// R4 - Three-bit gain 1x to 8x, resets 8x
// R5 - Conversion lengthens as gain decreases
// R6 - Start source field picks seven triggers
// R7 - Busy write starts single conversion
// R8 - Software waits one cycle before polling busy
// R9 - Continuous modes begin after busy set
// R10 - Complete interrupt when enable bit set
// R11 - Resolution 12/13/14/16, unconverted bits zero
// R12 - Interrupt only after final accumulated conversion
// R13 - Source 111b enables auto-scan over range
// R14 - Start channel write copies into mux
// R15 - Busy write begins auto-scan sequence
// R16 - Advance to next channel after accumulation
// R17 - After end channel reload start channel
// R18 - Scan converts channels even if digital
// R19 - Debug halt finishes current rotation first; code stops after the current conversion
// R20 - Scan keeps running in suspend, wakes
// R21 - Flag set when result exceeds threshold
// R22 - Flag stops scan until busy written
// R23 - Busy reads one while converting
// R24 - Software programs range before busy, start<=end
`timescale 1ns/100ps
`include "css_defs.svh"
module css_top #(
  parameter int NCH = 38
) (
  // Clock and reset
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           ce,
  // AHB-Lite slave
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic [31:0]         hrdata,
  output logic                hreadyout,
  output logic                hresp,
  // Device events and pins
  input  wire css_pkg::css_evt_t evt,
  input  wire logic [NCH-1:0] analog_cfg,
  input  wire logic [NCH-1:0] port_latch,
  input  wire logic [15:0]    fe_result,
  // Outputs
  output logic [NCH-1:0]      pin_ground,
  output logic                complete_irq,
  output logic                wake,
  output logic                conv_active
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic                sense_enable;
  logic                conversion_busy;
  logic                threshold_exceeded_flag;
  logic                cpt_flag;
  logic [2:0]          src;
  logic [2:0]          gain_select;
  logic [1:0]          resolution_select;
  logic [5:0]          input_channel_select;
  logic [5:0]          scan_start_channel;
  logic [5:0]          scan_end_channel;
  logic [15:0]         threshold_pair;
  logic [15:0]         result;
  logic                complete_irq_enable;
  logic                scan_hold;
  logic                halt_pend;
  logic [7:0]          ph_addr;
  logic                ph_wr;
  logic                ph_valid;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire addr_ph   = hsel && hready && htrans[1];
  wire wr_ctrl   = ph_valid && ph_wr && ph_addr == `CSS_OFF_CTRL;
  wire wr_cfg    = ph_valid && ph_wr && ph_addr == `CSS_OFF_CFG;
  wire wr_md1    = ph_valid && ph_wr && ph_addr == `CSS_OFF_MD1;
  wire wr_md2    = ph_valid && ph_wr && ph_addr == `CSS_OFF_MD2;
  wire wr_mux    = ph_valid && ph_wr && ph_addr == `CSS_OFF_MUX;
  wire wr_ss     = ph_valid && ph_wr && ph_addr == `CSS_OFF_SS;
  wire wr_se     = ph_valid && ph_wr && ph_addr == `CSS_OFF_SE;
  wire wr_thr    = ph_valid && ph_wr && ph_addr == `CSS_OFF_THR;
  wire wr_ien    = ph_valid && ph_wr && ph_addr == `CSS_OFF_IEN;
  wire rd_now    = addr_ph && !hwrite;

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  wire css_pkg::css_src_t src_e = css_pkg::css_src_t'(src);
  wire scan_mode = src_e == css_pkg::CSS_SRC_SCAN;                                       // R13
  wire cont_mode = src_e == css_pkg::CSS_SRC_CONT || scan_mode;
  wire busy_wr   = wr_ctrl && hwdata[`CSS_CTRL_BUSY];
  logic timer_trig;
  always_comb begin
    case (src_e)                                                                         // R6
      css_pkg::CSS_SRC_T0: timer_trig = evt.t_ovf[0];
      css_pkg::CSS_SRC_T2: timer_trig = evt.t_ovf[2];
      css_pkg::CSS_SRC_T1: timer_trig = evt.t_ovf[1];
      css_pkg::CSS_SRC_T3: timer_trig = evt.t_ovf[3];
      default:             timer_trig = 1'b0;
    endcase
  end

  typedef enum logic [1:0] {S_IDLE, S_CONV, S_DONE} css_state_t;
  css_state_t state;
  logic       conv_done;
  logic       running;
  wire  idle      = state == S_IDLE;
  wire  start_req = sense_enable && idle && (                                            // R1
                    (busy_wr && !cont_mode) ||                                           // R7
                    (timer_trig && !cont_mode) ||
                    (cont_mode && running && !scan_hold && !halt_pend));                  // R9 R22
  wire  at_end    = input_channel_select == scan_end_channel;
  wire  over_thr  = fe_result > threshold_pair;                                          // R21
  wire [15:0] res_mask = (resolution_select == 2'h0) ? 16'hFFF0 :
                         (resolution_select == 2'h1) ? 16'hFFF8 :
                         (resolution_select == 2'h2) ? 16'hFFFC : 16'hFFFF;

  css_timer u_timer (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .start   (start_req),
    .gain    (gain_select),                                                              // R5
    .res     (resolution_select),
    .done    (conv_done)
  );

  logic [NCH-1:0] next_ground;
  css_ground #(.NCH(NCH)) u_ground (
    .analog_cfg (analog_cfg),
    .port_latch (port_latch),
    .channel    (input_channel_select),
    .active     (state == S_CONV),                                                       // R3
    .ground     (next_ground)
  );

  // ----------------------------------------------------------------
  // Bus slave and register writes
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_wr    <= 1'b0;
      ph_addr  <= 8'h00;
      hrdata   <= 32'h0000_0000;
    end else if (ce) begin
      ph_valid <= addr_ph;
      ph_wr    <= hwrite;
      ph_addr  <= haddr[7:0];
      if (rd_now) begin
        case (haddr[7:0])
          `CSS_OFF_CTRL: hrdata <= {24'h0, sense_enable, 1'b0, cpt_flag, conversion_busy,  // R23
                                   3'h0, threshold_exceeded_flag};
          `CSS_OFF_CFG:  hrdata <= {25'h0, src, 4'h0};
          `CSS_OFF_MD1:  hrdata <= {29'h0, gain_select};
          `CSS_OFF_MD2:  hrdata <= {30'h0, resolution_select};
          `CSS_OFF_MUX:  hrdata <= {26'h0, input_channel_select};
          `CSS_OFF_SS:   hrdata <= {26'h0, scan_start_channel};
          `CSS_OFF_SE:   hrdata <= {26'h0, scan_end_channel};
          `CSS_OFF_THR:  hrdata <= {16'h0, threshold_pair};
          `CSS_OFF_RES:  hrdata <= {16'h0, result};
          `CSS_OFF_IEN:  hrdata <= {31'h0, complete_irq_enable};
          default:       hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sense_enable        <= 1'b0;
      src                 <= 3'h0;
      gain_select         <= `CSS_GAIN_RESET;                                            // R4
      resolution_select   <= `CSS_RES_RESET;                                             // R11
      scan_start_channel  <= 6'h00;
      scan_end_channel    <= 6'h00;
      threshold_pair      <= `CSS_THR_RESET;
      complete_irq_enable <= 1'b0;
    end else if (ce) begin
      if (wr_ctrl) sense_enable <= hwdata[`CSS_CTRL_EN];
      if (wr_cfg)  src <= hwdata[`CSS_CFG_SRC_HI:`CSS_CFG_SRC_LO];                        // R6
      if (wr_md1)  gain_select <= hwdata[2:0];
      if (wr_md2)  resolution_select <= hwdata[1:0];
      if (wr_ss)   scan_start_channel <= hwdata[5:0];
      if (wr_se)   scan_end_channel <= hwdata[5:0];
      if (wr_thr)  threshold_pair <= hwdata[15:0];
      if (wr_ien)  complete_irq_enable <= hwdata[`CSS_IEN_CPT];
    end
  end

  // ----------------------------------------------------------------
  // Conversion sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state                   <= S_IDLE;
      conversion_busy         <= 1'b0;
      running                 <= 1'b0;
      scan_hold               <= 1'b0;
      halt_pend               <= 1'b0;
      threshold_exceeded_flag <= 1'b0;
      cpt_flag                <= 1'b0;
      input_channel_select    <= 6'h00;
      result                  <= 16'h0000;
      pin_ground              <= '0;
      complete_irq            <= 1'b0;
      wake                    <= 1'b0;
      conv_active             <= 1'b0;
    end else if (ce) begin
      pin_ground   <= next_ground;
      conv_active  <= state == S_CONV;
      complete_irq <= cpt_flag && complete_irq_enable;                                    // R10
      wake         <= 1'b0;
      if (busy_wr && sense_enable) begin
        conversion_busy <= 1'b1;
        scan_hold       <= 1'b0;                                                          // R22
        running         <= cont_mode;                                                     // R9 R15
      end
      if (!sense_enable) running <= 1'b0;                                                 // R1
      // Halt blocks new conversions after the current one; running clears only at a rotation boundary.
      if (evt.debug_halt && scan_mode && running) halt_pend <= 1'b1;                      // R19
      if (!evt.debug_halt) halt_pend <= 1'b0;
      if (wr_mux) input_channel_select <= hwdata[5:0];
      if (wr_ss && scan_mode) input_channel_select <= hwdata[5:0];                        // R14
      if (wr_ctrl && !hwdata[`CSS_CTRL_INT]) cpt_flag <= 1'b0;
      if (wr_ctrl && !hwdata[`CSS_CTRL_CMPF]) threshold_exceeded_flag <= 1'b0;
      case (state)
        S_IDLE: begin
          if (start_req) begin
            state           <= S_CONV;
            conversion_busy <= 1'b1;
          end
        end
        S_CONV: begin
          if (conv_done) state <= S_DONE;
        end
        S_DONE: begin
          state                   <= S_IDLE;
          result                  <= fe_result & res_mask;                                // R11 R12
          cpt_flag                <= 1'b1;                                                // R12
          threshold_exceeded_flag <= over_thr;                                            // R21
          conversion_busy         <= cont_mode && running;                                // R23
          if (scan_mode && running) begin
            if (over_thr) begin
              scan_hold       <= 1'b1;                                                    // R22
              conversion_busy <= 1'b0;
              wake            <= evt.suspend;                                             // R20
            end else if (at_end) begin
              input_channel_select <= scan_start_channel;                                 // R17
              if (halt_pend) begin
                running         <= 1'b0;                                                  // R19
                conversion_busy <= 1'b0;
              end
            end else begin
              input_channel_select <= 6'(input_channel_select + 6'h01);                   // R16 R18
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_off_no_start: assert property (@(posedge hclk) disable iff (!hresetn)             // R1
    !sense_enable |-> !start_req) else $error("start while disabled");
  chk_scan_wrap: assert property (@(posedge hclk) disable iff (!hresetn)                // R17
    ce && state == S_DONE && scan_mode && running && !over_thr && at_end
    |=> input_channel_select == $past(scan_start_channel)) else $error("no wrap");
  chk_scan_step: assert property (@(posedge hclk) disable iff (!hresetn)                // R16
    ce && state == S_DONE && scan_mode && running && !over_thr && !at_end && !wr_mux && !wr_ss
    |=> input_channel_select == 6'($past(input_channel_select) + 6'h01)) else $error("no step");
  chk_cmp_flag: assert property (@(posedge hclk) disable iff (!hresetn)                 // R21
    ce && state == S_DONE |=> threshold_exceeded_flag == $past(over_thr)) else $error("flag wrong");
  chk_hold_stops: assert property (@(posedge hclk) disable iff (!hresetn)               // R22
    scan_hold && !busy_wr |-> !start_req) else $error("scan ran on hold");
  chk_ss_copy: assert property (@(posedge hclk) disable iff (!hresetn)                  // R14
    ce && wr_ss && scan_mode && state != S_DONE |=> input_channel_select == $past(hwdata[5:0]))
    else $error("start channel not copied");
  chk_busy_conv: assert property (@(posedge hclk) disable iff (!hresetn)                // R23
    state == S_CONV |-> conversion_busy) else $error("busy low in conversion");
  chk_ground_self: assert property (@(posedge hclk) disable iff (!hresetn)              // R3
    state != S_CONV |-> next_ground == '0) else $error("ground while idle");
  chk_irq_gate: assert property (@(posedge hclk) disable iff (!hresetn)                 // R10
    ce && !complete_irq_enable |=> !complete_irq) else $error("irq not gated");
  cov_single: cover property (@(posedge hclk) busy_wr ##1 state == S_CONV);
  cov_wrap:   cover property (@(posedge hclk) state == S_DONE && scan_mode && at_end);
  chk_busy_start: assert property (@(posedge hclk) disable iff (!hresetn)               // R7
    ce && idle && sense_enable && busy_wr && !cont_mode |=> state == S_CONV)
    else $error("busy write did not start");
  chk_timer_start: assert property (@(posedge hclk) disable iff (!hresetn)              // R6
    ce && idle && sense_enable && timer_trig && !cont_mode |=> state == S_CONV)
    else $error("timer trigger did not start");
  chk_cont_repeat: assert property (@(posedge hclk) disable iff (!hresetn)              // R9
    ce && idle && sense_enable && cont_mode && running && !scan_hold && !halt_pend |=> state == S_CONV)
    else $error("continuous mode did not restart");
  chk_irq_follow: assert property (@(posedge hclk) disable iff (!hresetn)               // R10
    ce && cpt_flag && complete_irq_enable |=> complete_irq)
    else $error("irq not raised");
  chk_res_zero: assert property (@(posedge hclk) disable iff (!hresetn)                 // R11
    ce && state == S_DONE |=> (result & ~$past(res_mask)) == 16'h0000)
    else $error("unconverted bits not zero");
  chk_halt_stop: assert property (@(posedge hclk) disable iff (!hresetn)                // R19
    ce && state == S_DONE && scan_mode && running && !over_thr && at_end && halt_pend |=> !running)
    else $error("scan ran past halt");
  chk_wake_pulse: assert property (@(posedge hclk) disable iff (!hresetn)               // R20
    ce && state == S_DONE && scan_mode && running && over_thr && evt.suspend |=> wake)
    else $error("no wake in suspend");
  chk_busy_done: assert property (@(posedge hclk) disable iff (!hresetn)                // R23
    ce && state == S_DONE && !cont_mode |=> !conversion_busy)
    else $error("busy stuck after result");
  cov_hold:   cover property (@(posedge hclk) $rose(scan_hold));
  cov_cont:   cover property (@(posedge hclk) cont_mode && state == S_DONE);
  cov_timer:  cover property (@(posedge hclk) timer_trig && idle && sense_enable);
endmodule
